// File: src/cmd_handler_pkg.sv
// Purpose: constants and types of the command handler
// Assumes: single 100 MHz clock domain
// Notes:   register indices are word indices
`default_nettype none
package cmd_handler_pkg;
  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  REG_CMD       = 8'h00;
  localparam logic [7:0]  REG_STB       = 8'h01;
  localparam logic [7:0]  REG_SPOLL     = 8'h02;
  localparam logic [7:0]  REG_SRE       = 8'h03;
  localparam logic [7:0]  REG_VOLT_IMM  = 8'h04;
  localparam logic [7:0]  REG_CURR_IMM  = 8'h05;
  localparam logic [7:0]  REG_VOLT_TRIG = 8'h06;
  localparam logic [7:0]  REG_CURR_TRIG = 8'h07;
  localparam logic [7:0]  REG_VOLT_ACT  = 8'h08;
  localparam logic [7:0]  REG_CURR_ACT  = 8'h09;
  localparam logic [7:0]  REG_TRIG_CTL  = 8'h0a;
  localparam logic [7:0]  REG_NUM_MAG   = 8'h0b;
  localparam logic [7:0]  REG_NUM_CTL   = 8'h0c;
  localparam logic [7:0]  REG_ERR       = 8'h0d;
  localparam logic [7:0]  REG_TEST      = 8'h0e;
  localparam logic [7:0]  REG_CONTRAST  = 8'h0f;
  localparam logic [7:0]  REG_NV        = 8'h10;
  localparam logic [7:0]  REG_RESP_IN   = 8'h11;
  localparam logic [7:0]  REG_RESP_OUT  = 8'h12;
  localparam logic [7:0]  REG_CAL_GAIN  = 8'h13;
  localparam logic [7:0]  REG_MSG       = 8'h14;
  // ----------------------------------------------------------------
  // command codes, status byte layout, limits, error codes
  // ----------------------------------------------------------------
  localparam logic [3:0]  CMD_TRG       = 4'h1;
  localparam logic [3:0]  CMD_ABORT     = 4'h2;
  localparam logic [3:0]  CMD_INIT      = 4'h3;
  localparam logic [3:0]  CMD_TEST      = 4'h4;
  localparam logic [3:0]  CMD_MSG_CLR   = 4'h5;
  localparam int          STB_OPER      = 7;
  localparam int          STB_MSS       = 6;
  localparam int          STB_ESB       = 5;
  localparam int          STB_MAV       = 4;
  localparam int          STB_QUES      = 3;
  localparam int          STB_ERR       = 2;
  localparam logic [3:0]  MAX_FRAC      = 4'h8;
  localparam logic [31:0] MAX_INT_MAG   = 32'd400000000;
  localparam logic [3:0]  MAX_EXP       = 4'h8;
  localparam logic [7:0]  MSG_MAX       = 8'd253;
  localparam logic [31:0] CONTRAST_MAX  = 32'd9;
  localparam logic [3:0]  FRAC_CONTRAST = 4'h1;
  localparam logic signed [15:0] ERR_SYNTAX = 16'shff88;
  localparam logic signed [15:0] ERR_RANGE  = 16'shff22;
  localparam logic [2:0]  TGT_VOLT_IMM  = 3'h0;
  localparam logic [2:0]  TGT_CURR_IMM  = 3'h1;
  localparam logic [2:0]  TGT_VOLT_TRIG = 3'h2;
  localparam logic [2:0]  TGT_CURR_TRIG = 3'h3;
  localparam logic [2:0]  TGT_CONTRAST  = 3'h4;
  // ----------------------------------------------------------------
  // reset values, crc, response format
  // ----------------------------------------------------------------
  localparam logic [31:0] LEVEL_RST     = 32'h0000_0000;
  localparam logic [7:0]  SRE_RST       = 8'h00;
  localparam logic [31:0] GAIN_RST      = 32'h0000_8000;
  localparam int          GAIN_SHIFT    = 15;
  localparam logic [7:0]  CRC_POLY      = 8'h07;
  localparam logic [31:0] MANT_LOW      = 32'd100000;
  localparam logic [31:0] MANT_HIGH     = 32'd1000000;
  localparam logic signed [7:0] MANT_POINT = 8'sd5;
  localparam logic signed [7:0] UNIT_EXP   = -8'sd3;

  typedef struct packed {
    logic [31:0] volt;
    logic [31:0] curr;
  } level_t;

  typedef struct packed {
    logic oper;
    logic esb;
    logic mav;
    logic ques;
  } status_in_t;

  typedef struct packed {
    logic       syntax_err;
    logic [3:0] exponent;
    logic [3:0] frac_digits;
    logic [2:0] target;
  } num_ctl_t;
endpackage : cmd_handler_pkg
`default_nettype wire

// File: src/status_trigger_command_handler.sv
// Purpose: status, trigger and command logic of a dc source
//          (poll, abort, self test, numbers, format, contrast)
// Assumes: a front end decodes messages onto the register port
// Notes:   one clock
// Function
// - status query: byte 0..255, unchanged
// - status byte reads never clear status
// - bit six summarises service reasons
// - poll shows request flag, then clears it
// - trigger acts only while armed
// - trigger loads pending levels
// - trigger needs listener address
// - self test: storage crc, 0 pass 1 fail
// - parser: 8 fraction digits, 4e8 magnitude
// - over-limit values dropped silently
// - messages capped at 253 characters
// - responses as mantissa and exponent
// - malformed numbers queue -120
// - out-of-range values queue -222
// - abort: immediate to pending, unarm
// - abort runs after power-on
// - contrast 0..9, kept in storage
// - enabled bits ORed to bit six
// - status byte layout, bits 1..0 unused
// - continuous mode stays armed
//
// Implementation choices: the register addresses and the address-and-strobe port.
`default_nettype none
module status_trigger_command_handler
  import cmd_handler_pkg::*;
#(
  parameter int          ERRQ_DEPTH = 4,
  parameter int          NV_WORDS   = 16,
  parameter logic [31:0] VOLT_MAX   = 32'd1000000,
  parameter logic [31:0] CURR_MAX   = 32'd40000
)(
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic [cmd_handler_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]                 wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic [31:0]                      rdata,
  input  wire logic                        listen_addressed,
  input  wire cmd_handler_pkg::status_in_t status_in,
  input  wire logic                        rx_char_valid,
  input  wire logic                        rx_msg_end,
  output cmd_handler_pkg::level_t          output_level,
  output logic [3:0]                       contrast,
  output logic                             service_request,
  output logic                             ready
);
  import cmd_handler_pkg::*;

  localparam int EQ_W = $clog2(ERRQ_DEPTH);
  localparam int NV_W = $clog2(NV_WORDS);

  generate
    if (ERRQ_DEPTH < 2 || (1 << EQ_W) != ERRQ_DEPTH || NV_WORDS < 2 || NV_WORDS > 256)
    begin : g_bad_param
      $error("bad queue depth or storage size");
    end
  endgenerate

  typedef enum logic [1:0] {ST_IDLE, ST_SCAN} scan_state_t;
  typedef enum logic [1:0] {FMT_IDLE, FMT_NORM} fmt_state_t;

  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    return c;
  endfunction : crc8_step

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic        wr_ok;
  logic        cmd_wr;
  logic        rd_ok;
  logic        cmd_trg;
  logic        cmd_abort;
  logic        cmd_init;
  logic        cmd_test;
  logic        cmd_msg_clr;
  num_ctl_t    num_ctl;
  logic        num_go;

  assign wr_ok       = wr_en && ready;
  assign rd_ok       = rd_en && ready;
  assign cmd_wr      = wr_ok && addr == REG_CMD;
  assign cmd_trg     = cmd_wr && wdata[3:0] == CMD_TRG && listen_addressed;
  assign cmd_abort   = cmd_wr && wdata[3:0] == CMD_ABORT;
  assign cmd_init    = cmd_wr && wdata[3:0] == CMD_INIT;
  assign cmd_test    = cmd_wr && wdata[3:0] == CMD_TEST;
  assign cmd_msg_clr = cmd_wr && wdata[3:0] == CMD_MSG_CLR;
  assign num_ctl     = wdata[11:0];
  assign num_go      = wr_ok && addr == REG_NUM_CTL;

  // ----------------------------------------------------------------
  // numeric parameter checks
  // ----------------------------------------------------------------
  logic [31:0] num_mag_reg;
  logic        num_over_limit;
  logic        num_syntax;
  logic        num_range;
  logic        num_apply;
  logic        err_push;
  logic signed [15:0] err_code;

  always_comb
  begin
    num_over_limit = num_ctl.frac_digits > MAX_FRAC || num_mag_reg > MAX_INT_MAG;
    num_syntax     = num_ctl.syntax_err || num_ctl.exponent > MAX_EXP;
    unique case (num_ctl.target)
      TGT_VOLT_IMM, TGT_VOLT_TRIG: num_range = num_mag_reg > VOLT_MAX;
      TGT_CURR_IMM, TGT_CURR_TRIG: num_range = num_mag_reg > CURR_MAX;
      TGT_CONTRAST: num_range = num_mag_reg > CONTRAST_MAX ||
                                num_ctl.frac_digits > FRAC_CONTRAST;
      default:      num_range = 1'b1;
    endcase
    num_apply = num_go && !num_over_limit && !num_syntax && !num_range;
    err_push  = num_go && !num_over_limit && (num_syntax || num_range);
    err_code  = num_syntax ? ERR_SYNTAX : ERR_RANGE;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      num_mag_reg <= LEVEL_RST;
    else if (wr_ok && addr == REG_NUM_MAG)
      num_mag_reg <= wdata;

  // ----------------------------------------------------------------
  // trigger levels, arming, power-on abort
  // ----------------------------------------------------------------
  level_t imm_reg;
  level_t pend_reg;
  level_t act_reg;
  logic   cont_reg;
  logic   wtg_reg;

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      ready <= 1'b0;
    else
      ready <= 1'b1;

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      imm_reg  <= '{volt: LEVEL_RST, curr: LEVEL_RST};
      pend_reg <= '{volt: LEVEL_RST, curr: LEVEL_RST};
      act_reg  <= '{volt: LEVEL_RST, curr: LEVEL_RST};
    end
    else if (!ready || cmd_abort)
      pend_reg <= imm_reg;
    else if (cmd_trg && wtg_reg)
      act_reg <= pend_reg;
    else if (num_apply)
      unique case (num_ctl.target)
        TGT_VOLT_IMM:  imm_reg.volt  <= num_mag_reg;
        TGT_CURR_IMM:  imm_reg.curr  <= num_mag_reg;
        TGT_VOLT_TRIG: pend_reg.volt <= num_mag_reg;
        TGT_CURR_TRIG: pend_reg.curr <= num_mag_reg;
        default:       ;
      endcase

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      cont_reg <= 1'b0;
    else if (wr_ok && addr == REG_TRIG_CTL)
      cont_reg <= wdata[0];

  // abort wins; continuous re-arms next cycle
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      wtg_reg <= 1'b0;
    else if (!ready || cmd_abort)
      wtg_reg <= 1'b0;
    else if (cont_reg || cmd_init)
      wtg_reg <= 1'b1;
    else if (cmd_trg)
      wtg_reg <= 1'b0;

  assign output_level = act_reg;

  // ----------------------------------------------------------------
  // status byte and service request
  // ----------------------------------------------------------------
  logic [7:0] sre_reg;
  logic [7:0] stb_raw;
  logic       mss;
  logic       mss_q;
  logic       rqs_reg;
  logic [EQ_W:0] err_cnt_reg;

  always_comb
  begin
    stb_raw           = 8'h00;
    stb_raw[STB_OPER] = status_in.oper;
    stb_raw[STB_ESB]  = status_in.esb;
    stb_raw[STB_MAV]  = status_in.mav;
    stb_raw[STB_QUES] = status_in.ques;
    stb_raw[STB_ERR]  = err_cnt_reg != '0;
    mss               = |(stb_raw & sre_reg);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      sre_reg <= SRE_RST;
    else if (wr_ok && addr == REG_SRE)
      sre_reg <= wdata[7:0] & ~(8'h01 << STB_MSS);

  // set beats the poll clear
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      mss_q   <= 1'b0;
      rqs_reg <= 1'b0;
    end
    else
    begin
      mss_q <= mss;
      if (mss && !mss_q)
        rqs_reg <= 1'b1;
      else if (rd_ok && addr == REG_SPOLL)
        rqs_reg <= 1'b0;
    end

  assign service_request = rqs_reg;

  // ----------------------------------------------------------------
  // error queue
  // ----------------------------------------------------------------
  logic signed [15:0] errq [ERRQ_DEPTH];
  logic [EQ_W-1:0]    err_wr_reg;
  logic [EQ_W-1:0]    err_rd_reg;
  logic               err_pop;
  logic               err_put;

  assign err_pop = rd_ok && addr == REG_ERR && err_cnt_reg != '0;
  assign err_put = err_push && (err_cnt_reg != (EQ_W + 1)'(ERRQ_DEPTH) || err_pop);

  always_ff @(posedge sys_clk)
    if (err_put)
      errq[err_wr_reg] <= err_code;

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      err_wr_reg  <= '0;
      err_rd_reg  <= '0;
      err_cnt_reg <= '0;
    end
    else
    begin
      err_wr_reg  <= err_wr_reg + EQ_W'(err_put);
      err_rd_reg  <= err_rd_reg + EQ_W'(err_pop);
      err_cnt_reg <= err_cnt_reg + (EQ_W + 1)'(err_put) - (EQ_W + 1)'(err_pop);
    end

  // ----------------------------------------------------------------
  // storage model, contrast, crc self test
  // ----------------------------------------------------------------
  // cleared at reset for a clean start;
  // an all-zero image has a valid zero crc
  logic [7:0]     nv_mem [NV_WORDS];
  logic [NV_W-1:0] nv_idx_reg;
  scan_state_t    scan_state;
  logic           scan_seal_reg;
  logic [NV_W-1:0] scan_idx_reg;
  logic [7:0]     crc_reg;
  logic           test_fail_reg;
  logic           nv_user_wr;
  logic           contrast_wr;
  logic           seal_wr;

  assign nv_user_wr  = wr_ok && addr == REG_NV;
  assign contrast_wr = num_apply && num_ctl.target == TGT_CONTRAST;
  assign seal_wr     = scan_state == ST_SCAN && scan_seal_reg &&
                       scan_idx_reg == NV_W'(NV_WORDS - 1);
  assign contrast    = nv_mem[0][3:0];

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      nv_idx_reg <= '0;
    else if (nv_user_wr)
      nv_idx_reg <= wdata[NV_W+7:8];

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      for (int i = 0; i < NV_WORDS; i++)
        nv_mem[i] <= 8'h00;
    else if (contrast_wr)
      nv_mem[0] <= {4'h0, num_mag_reg[3:0]};
    else if (seal_wr)
      nv_mem[NV_WORDS-1] <= crc_reg;
    else if (nv_user_wr)
      nv_mem[wdata[NV_W+7:8]] <= wdata[7:0];

  // contrast store reseals the crc
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      scan_state    <= ST_IDLE;
      scan_seal_reg <= 1'b0;
      scan_idx_reg  <= '0;
      crc_reg       <= 8'h00;
      test_fail_reg <= 1'b0;
    end
    else
      unique case (scan_state)
        ST_IDLE:
          if (contrast_wr || cmd_test)
          begin
            scan_state    <= ST_SCAN;
            scan_seal_reg <= contrast_wr;
            scan_idx_reg  <= '0;
            crc_reg       <= 8'h00;
          end
        ST_SCAN:
          if (scan_idx_reg == NV_W'(NV_WORDS - 1))
          begin
            scan_state <= ST_IDLE;
            if (!scan_seal_reg)
              test_fail_reg <= crc_reg != nv_mem[NV_WORDS-1];
          end
          else
          begin
            crc_reg      <= crc8_step(crc_reg, nv_mem[scan_idx_reg]);
            scan_idx_reg <= scan_idx_reg + 1'b1;
          end
        default:
          scan_state <= ST_IDLE;
      endcase

  // ----------------------------------------------------------------
  // response formatting
  // ----------------------------------------------------------------
  fmt_state_t        fmt_state;
  logic [31:0]       gain_reg;
  logic [31:0]       mant_reg;
  logic signed [7:0] exp_reg;
  logic [63:0]       scaled;

  assign scaled = wdata * gain_reg;

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      gain_reg <= GAIN_RST;
    else if (wr_ok && addr == REG_CAL_GAIN)
      gain_reg <= wdata;

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      fmt_state <= FMT_IDLE;
      mant_reg  <= '0;
      exp_reg   <= '0;
    end
    else
      unique case (fmt_state)
        FMT_IDLE:
          if (wr_ok && addr == REG_RESP_IN)
          begin
            fmt_state <= FMT_NORM;
            mant_reg  <= scaled[GAIN_SHIFT+31:GAIN_SHIFT];
            exp_reg   <= MANT_POINT + UNIT_EXP;
          end
        FMT_NORM:
          if (mant_reg >= MANT_HIGH)
          begin
            mant_reg <= mant_reg / 32'd10;
            exp_reg  <= exp_reg + 8'sd1;
          end
          else if (mant_reg != '0 && mant_reg < MANT_LOW)
          begin
            mant_reg <= mant_reg * 32'd10;
            exp_reg  <= exp_reg - 8'sd1;
          end
          else
          begin
            fmt_state <= FMT_IDLE;
            if (mant_reg == '0)
              exp_reg <= '0;
          end
        default:
          fmt_state <= FMT_IDLE;
      endcase

  // ----------------------------------------------------------------
  // message length guard
  // ----------------------------------------------------------------
  logic [7:0] msg_len_reg;
  logic       msg_over_reg;

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      msg_len_reg <= '0;
    else if (rx_msg_end)
      msg_len_reg <= '0;
    else if (rx_char_valid && msg_len_reg < MSG_MAX)
      msg_len_reg <= msg_len_reg + 8'd1;

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      msg_over_reg <= 1'b0;
    else if (rx_char_valid && !rx_msg_end && msg_len_reg == MSG_MAX)
      msg_over_reg <= 1'b1;
    else if (cmd_msg_clr)
      msg_over_reg <= 1'b0;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      rdata <= '0;
    else if (rd_ok)
      unique case (addr)
        REG_STB:       rdata <= {24'h0, stb_raw | (8'(mss) << STB_MSS)};
        REG_SPOLL:     rdata <= {24'h0, stb_raw | (8'(rqs_reg) << STB_MSS)};
        REG_SRE:       rdata <= {24'h0, sre_reg};
        REG_VOLT_IMM:  rdata <= imm_reg.volt;
        REG_CURR_IMM:  rdata <= imm_reg.curr;
        REG_VOLT_TRIG: rdata <= pend_reg.volt;
        REG_CURR_TRIG: rdata <= pend_reg.curr;
        REG_VOLT_ACT:  rdata <= act_reg.volt;
        REG_CURR_ACT:  rdata <= act_reg.curr;
        REG_TRIG_CTL:  rdata <= {30'h0, wtg_reg, cont_reg};
        REG_NUM_MAG:   rdata <= num_mag_reg;
        REG_ERR:       rdata <= {8'h0, 8'(err_cnt_reg),
                                 err_cnt_reg != '0 ? errq[err_rd_reg] : 16'sh0000};
        REG_TEST:      rdata <= {30'h0, scan_state == ST_SCAN, test_fail_reg};
        REG_CONTRAST:  rdata <= {28'h0, contrast};
        REG_NV:        rdata <= {24'h0, nv_mem[nv_idx_reg]};
        REG_RESP_OUT:  rdata <= {fmt_state == FMT_NORM, exp_reg[6:0], mant_reg[23:0]};
        REG_CAL_GAIN:  rdata <= gain_reg;
        REG_MSG:       rdata <= {23'h0, msg_over_reg, msg_len_reg};
        default:       rdata <= '0;
      endcase
    else
      rdata <= '0;
endmodule : status_trigger_command_handler
`default_nettype wire

// File: verification/cmd_handler_checker.sv
// Purpose: port assertions of the command handler
// Assumes: one clock domain, reset_n async low
// Notes:   bound at the foot
`default_nettype none
module cmd_handler_checker
  import cmd_handler_pkg::*;
(
  input wire logic                          sys_clk,
  input wire logic                          reset_n,
  input wire logic [cmd_handler_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0]                   wdata,
  input wire logic                          wr_en,
  input wire logic                          rd_en,
  input wire logic [31:0]                   rdata,
  input wire logic                          listen_addressed,
  input wire cmd_handler_pkg::status_in_t   status_in,
  input wire logic                          rx_char_valid,
  input wire logic                          rx_msg_end,
  input wire cmd_handler_pkg::level_t       output_level,
  input wire logic [3:0]                    contrast,
  input wire logic                          service_request,
  input wire logic                          ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // port rules
  // ------
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  wire logic stb_rd = rd_en && ready && addr == REG_STB;
  wire logic poll_rd = rd_en && ready && addr == REG_SPOLL;
  wire logic trg_hit = wr_en && ready && addr == REG_CMD && wdata[3:0] == CMD_TRG;
  wire logic trg_ok = trg_hit && listen_addressed;
  sequence trg_s;
    trg_hit;
  endsequence
  sequence quiet_s;
    $stable(output_level) [*2];
  endsequence
  AST_RD_IDLE: assert property (!rd_en |=> rdata == 32'h0)
    else $error("read data not idle");
  AST_STB_FMT: assert property (
    stb_rd |=> rdata[31:8] == 24'h0 && rdata[1:0] == 2'h0)
    else $error("status layout");
  AST_STB_OPER: assert property (
    stb_rd && $stable(status_in) |=> rdata[STB_OPER] == $past(status_in.oper))
    else $error("oper bit");
  AST_POLL_RQS: assert property (poll_rd && service_request |=> rdata[STB_MSS])
    else $error("poll lost request");
  AST_TRG_DEAF: assert property (trg_s ##0 !listen_addressed |=> quiet_s)
    else $error("deaf trigger moved level");
  AST_READY: assert property (!ready |=> ready)
    else $error("ready late");
  AST_CONTRAST: assert property (contrast <= 4'h9)
    else $error("contrast beyond nine");
  // levels move only after a trigger
  AST_LVL_CAUSE: assert property (
    !$stable(output_level) |-> $past(trg_ok) || $past(trg_ok, 2) || $past(trg_ok, 3))
    else $error("level moved untriggered");
endmodule : cmd_handler_checker
bind status_trigger_command_handler cmd_handler_checker u_chk (
  .sys_clk, .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .listen_addressed,
  .status_in, .rx_char_valid, .rx_msg_end, .output_level, .contrast,
  .service_request, .ready);
`default_nettype wire

// File: verification/msg_source_model.sv
// Purpose: host model that streams characters
// Assumes: one character per enabled cycle
// Notes:   slow mode sends only every second cycle
`default_nettype none
module msg_source_model
(
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic [8:0] count,
  input  wire logic       slow,
  input  wire logic       close,
  output logic            rx_char_valid,
  output logic            rx_msg_end,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // character stream
  // ------
  logic [8:0] left_reg = 9'h0;
  logic       phase_reg = 1'b0;
  assign busy = left_reg != 9'h0;
  assign rx_char_valid = busy && (!slow || phase_reg);
  assign rx_msg_end = close && !busy;
  always @(posedge sys_clk)
  begin
    phase_reg <= !phase_reg;
    if (go)
      left_reg <= count;
    else if (rx_char_valid)
      left_reg <= left_reg - 9'h1;
  end
endmodule : msg_source_model
`default_nettype wire

// File: verification/status_trigger_command_handler_test.sv
// Purpose: self-checking bench of the command handler
// Assumes: 100 MHz sys_clk, reset_n low for six cycles
// Notes:   fixed random seed
`default_nettype none
module status_trigger_command_handler_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cmd_handler_pkg::*;
  localparam logic [31:0] VMAX = 32'd1000000;
  localparam logic [31:0] IMAX = 32'd40000;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, got;
  logic        wr_en = 1'b0, rd_en = 1'b0, listen = 1'b1;
  logic        go = 1'b0, slow = 1'b0, close = 1'b0;
  logic        rxv, rxe, mbusy, sreq, rdy;
  logic [8:0]  n = 9'h0;
  logic [3:0]  contrast;
  logic [7:0]  sre;
  level_t      lvl;
  status_in_t  st = '0;
  logic [31:0] v [4];
  int          error_cnt = 0;
  int          checked = 0;
  int          seed = 32'hde07;
  // parser corner cases
  logic [31:0] t_mag [8] = '{32'd1, 32'd400000001, 32'd1, 32'd1, VMAX + 32'd1,
                             32'd400000000, 32'd10, 32'd9};
  logic [31:0] t_ctl [8] = '{32'h48, 32'h0, 32'h800, 32'h480, 32'h0, 32'h0, 32'h4, 32'hc};
  logic [31:0] t_err [8] = '{32'h0, 32'h0, 32'h1ff88, 32'h1ff88, 32'h1ff22, 32'h1ff22,
                             32'h1ff22, 32'h0};
  always #5 sys_clk = ~sys_clk;
  status_trigger_command_handler #(.VOLT_MAX(VMAX), .CURR_MAX(IMAX)) DUT (
    .sys_clk, .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .listen_addressed(listen), .status_in(st), .rx_char_valid(rxv), .rx_msg_end(rxe),
    .output_level(lvl), .contrast, .service_request(sreq), .ready(rdy));
  msg_source_model u_host (.sys_clk, .go, .count(n), .slow, .close,
    .rx_char_valid(rxv), .rx_msg_end(rxe), .busy(mbusy));
  // ------
  // helpers
  // ------
  function automatic logic [31:0] stb(input status_in_t s, input logic [7:0] e);
    logic [7:0] b;
    b = {s.oper, 1'b0, s.esb, s.mav, s.ques, 3'b000};
    b[STB_MSS] = |(b & e);
    return {24'h0, b};
  endfunction : stb
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic give_up;
    chk("wait bound", 32'h0, 32'h1);
    print_verdict();
  endtask : give_up
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 got = rdata;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("register %h", a), e, got);
  endtask : rchk
  task automatic num(input logic [31:0] m, input logic [31:0] c);
    wr(REG_NUM_MAG, m);
    wr(REG_NUM_CTL, c);
  endtask : num
  task automatic poll;
    for (int i = 0; i < 64; i++)
    begin
      rd(REG_TEST);
      if (got[1] === 1'b0)
        return;
    end
    give_up();
  endtask : poll
  task automatic send(input logic [8:0] c);
    @(posedge sys_clk);
    n <= c;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 600 && mbusy; i++)
      @(posedge sys_clk);
    if (mbusy)
      give_up();
  endtask : send
  // ------
  // main sequence
  // ------
  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    rchk(REG_TRIG_CTL, 32'h0);
    wr(REG_CMD, 32'(CMD_TEST));
    poll();
    chk("self test", 32'h0, got);
    for (int i = 0; i < 4; i++)
    begin
      v[i] = {$random(seed)} % (i[0] ? IMAX : VMAX);
      num(v[i], 32'(i));
      rchk(REG_VOLT_IMM + 8'(i), v[i]);
    end
    wr(REG_CMD, 32'(CMD_TRG));
    rchk(REG_VOLT_ACT, 32'h0);
    wr(REG_CMD, 32'(CMD_INIT));
    listen <= 1'b0;
    wr(REG_CMD, 32'(CMD_TRG));
    rchk(REG_VOLT_ACT, 32'h0);
    rchk(REG_TRIG_CTL, 32'h2);
    listen <= 1'b1;
    wr(REG_CMD, 32'(CMD_TRG));
    rchk(REG_VOLT_ACT, v[2]);
    rchk(REG_CURR_ACT, v[3]);
    rchk(REG_TRIG_CTL, 32'h0);
    wr(REG_TRIG_CTL, 32'h1);
    wr(REG_CMD, 32'(CMD_INIT));
    num(v[0], 32'h2);
    wr(REG_CMD, 32'(CMD_TRG));
    rchk(REG_VOLT_ACT, v[0]);
    rchk(REG_TRIG_CTL, 32'h3);
    num(v[2], 32'h0);
    wr(REG_TRIG_CTL, 32'h0);
    wr(REG_CMD, 32'(CMD_ABORT));
    rchk(REG_VOLT_TRIG, v[2]);
    rchk(REG_CURR_TRIG, v[1]);
    rchk(REG_TRIG_CTL, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      num(t_mag[i], t_ctl[i]);
      rchk(REG_ERR, t_err[i]);
    end
    chk("contrast", 32'h9, 32'(contrast));
    poll();
    num(32'd3, 32'h4);
    rchk(REG_CONTRAST, 32'h3);
    chk("contrast", 32'h3, 32'(contrast));
    poll();
    wr(REG_NV, 32'h035a);
    wr(REG_CMD, 32'(CMD_TEST));
    poll();
    chk("self test", 32'h1, got);
    st <= 4'b1010;
    wr(REG_SRE, 32'hff);
    rchk(REG_SRE, 32'hbf);
    wr(REG_SRE, 32'h80);
    rchk(REG_STB, stb(st, 8'h80));
    rchk(REG_STB, stb(st, 8'h80));
    chk("request", 32'h1, 32'(sreq));
    rchk(REG_SPOLL, stb(st, 8'h80));
    chk("request", 32'h0, 32'(sreq));
    rchk(REG_SPOLL, 32'h90);
    for (int i = 0; i < 4; i++)
    begin
      st <= 4'($random(seed));
      sre = 8'($random(seed));
      wr(REG_SRE, 32'(sre));
      rchk(REG_STB, stb(st, sre & 8'hbf));
    end
    st <= '0;
    rchk(REG_STB, 32'h0);
    send(9'd253);
    rchk(REG_MSG, 32'd253);
    slow <= 1'b1;
    send(9'd1);
    rchk(REG_MSG, 32'h1fd);
    wr(REG_CMD, 32'(CMD_MSG_CLR));
    close <= 1'b1;
    @(posedge sys_clk);
    close <= 1'b0;
    rchk(REG_MSG, 32'h0);
    wr(REG_CAL_GAIN, 32'h10000);
    wr(REG_RESP_IN, 32'd13550);
    @(posedge sys_clk);
    rchk(REG_RESP_OUT, 32'h0104_2298);
    print_verdict();
  end
endmodule : status_trigger_command_handler_test
`default_nettype wire
